// file: logic/jrpsc_consts.svh
/*
  Constants of the receive-side serial link setup block: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by bare name, before any module that uses it.
*/
`ifndef JRPSC_CONSTS_SVH
`define JRPSC_CONSTS_SVH
// device register offsets
`define JRPSC_ADDR_LINK_CFG   12'h110
`define JRPSC_ADDR_LINK_PWR   12'h200
`define JRPSC_ADDR_LANE_PD    12'h201
`define JRPSC_ADDR_REF_DIV    12'h230
`define JRPSC_ADDR_CAL_CTRL_A 12'h2A7
`define JRPSC_ADDR_OVR_A      12'h2A8
`define JRPSC_ADDR_CODE_A     12'h2AC
`define JRPSC_ADDR_CAL_CTRL_B 12'h2AE
`define JRPSC_ADDR_OVR_B      12'h2AF
`define JRPSC_ADDR_CODE_B     12'h2B3
`define JRPSC_ADDR_OFS_FIRST  12'h2BB
`define JRPSC_ADDR_OFS_LAST   12'h2C2
// field positions and lane grouping
`define JRPSC_PWR_DOWN_BIT    0
`define JRPSC_CAL_GO_BIT      0
`define JRPSC_OVR_EN_BIT      4
`define JRPSC_OFS_SIGN_BIT    3
`define JRPSC_CAL_BUSY_BIT    4
`define JRPSC_BLK_A_LANES     8'hC3
// reset values
`define JRPSC_RST_LINK_PWR    8'h01
`define JRPSC_RST_LANE_PD     8'hFF
`define JRPSC_RST_REF_DIV     8'h01
// rates and ratios
`define JRPSC_BYTES_PER_PCLK  4
`define JRPSC_BITS_FACTOR     20
`define JRPSC_REF_RATIO       40
`define JRPSC_DESER_RATIO     40
`define JRPSC_LANE_MIN_MBPS   750
`define JRPSC_LANE_MAX_MBPS   12500
`define JRPSC_PFD_MIN_MHZ     35
`define JRPSC_PFD_MAX_MHZ     80
// timing
`define JRPSC_CLK_PERIOD_NS   20
`define JRPSC_CAL_TIME_NS     1000
`define JRPSC_CAL_CYCLES \
  ((`JRPSC_CAL_TIME_NS + `JRPSC_CLK_PERIOD_NS - 1) / `JRPSC_CLK_PERIOD_NS)
// controller register offsets and setup values
`define JRPSC_APB_CMD         8'h00
`define JRPSC_APB_STATUS      8'h04
`define JRPSC_APB_LINKCFG     8'h08
`define JRPSC_APB_CTRL        8'h0C
`define JRPSC_TERM_SETUP_A    8'h02
`define JRPSC_TERM_SETUP_B    8'h02
`endif

// file: logic/jrpsc_dev.sv
/*
  Receiver device end: link power, lane power, termination calibration with
  override and per-lane trim, resync request, rate enables, lane PLL dividers.
  Assumes the deframer, analog trim engine and tick sources run on clk;
  sysrefIn arrives from a pin.
*/
`include "jrpsc_consts.svh"
`default_nettype none
// Summary of operation
// RULE_01: eight lanes form one link, shared SYSREF
// RULE_02: lane count and interpolation in one register
// RULE_03: converter count is two when interpolating
// RULE_04: transmitter keeps lane rate within range
// RULE_05: any lane losing sync raises resync request; the device masks lanes whose power-down bit is set
// RULE_06: transmitter sends sync characters while requested
// RULE_07: eight identical channels, one-to-forty deserializing
// RULE_08: software clears power bit before link use
// RULE_09: lane power-down bit per physical lane
// RULE_10: software loads calibration setup values first
// RULE_11: calibration starts on both start bits rising
// RULE_12: block A lanes 0,1,6,7; B the rest
// RULE_13: calibration code readable in low nibble
// RULE_14: override bit selects bits three to one
// RULE_15: per-lane sign-magnitude offset on calibrated code
// RULE_16: processing clock is byte rate over four
// RULE_17: frame rate is byte rate over F
// RULE_18: lane PLL oscillator divided by two
// RULE_19: PLL reference divided into phase detector range
// RULE_20: start bits return low before rerunning calibration
module jrpsc_dev
  import jrpsc_pkg::*;
(
  jrpsc_link_if.dev        link,
  input  wire logic        byteTick,
  input  wire logic [7:0]  laneSyncLost,
  input  wire logic        sysrefIn,
  input  wire logic [3:0]  calMeasureA,
  input  wire logic [3:0]  calMeasureB,
  input  wire logic        vcoTick,
  input  wire logic        refTick,
  output var  logic        linkPowerDown,
  output var  logic [7:0]  lanePowerDown,
  output var  logic [31:0] laneTermCode,
  output var  logic [1:0]  converterCount,
  output var  logic [3:0]  octetsPerFrame,
  output var  logic        pclkEn,
  output var  logic        frameEn,
  output var  logic        sysrefPulse,
  output var  logic        quadClkEn,
  output var  logic        pfdEn
);
  wire logic clk = link.clk;
  wire logic resetn = link.resetn;

  logic [7:0]    linkCfg_r, linkPwr_r, lanePd_r, refDiv_r;
  logic [7:0]    calCtrlA_r, calCtrlB_r, ovrA_r, ovrB_r;
  logic [7:0]    ofs_r [8];
  logic [3:0]    codeA_r, codeB_r;
  logic [3:0]    laneCode_r [8];
  logic [5:0]    calCnt_r;
  jrpsc_cal_st_t calSt_r;
  logic          bothGo_r;
  logic [7:0]    rdData_r;
  logic          rdValid_r, resync_r;
  logic          sys1_r, sys2_r, sys3_r, sysStable_r;
  logic [1:0]    byteCnt_r;
  logic [2:0]    frameCnt_r;
  logic          quadPh_r;
  logic [7:0]    refCnt_r;

  // write decode
  wire logic [11:0] a = link.regAddr;
  wire logic        we = link.regWrEn;
  wire logic        isOfs = (a >= `JRPSC_ADDR_OFS_FIRST) && (a <= `JRPSC_ADDR_OFS_LAST);
  wire logic [2:0]  ofsIdx = 3'(a - `JRPSC_ADDR_OFS_FIRST);
  wire logic        calBusy = (calSt_r == CAL_RUN);

  // register writes; reset leaves link and all lanes powered down
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      linkCfg_r  <= 8'h00;
      linkPwr_r  <= `JRPSC_RST_LINK_PWR;
      lanePd_r   <= `JRPSC_RST_LANE_PD;
      refDiv_r   <= `JRPSC_RST_REF_DIV;
      calCtrlA_r <= 8'h00;
      calCtrlB_r <= 8'h00;
      ovrA_r     <= 8'h00;
      ovrB_r     <= 8'h00;
    end else if (we) begin
      if (a == `JRPSC_ADDR_LINK_CFG) linkCfg_r <= link.regWrData;  // see RULE_02
      if (a == `JRPSC_ADDR_LINK_PWR) linkPwr_r <= link.regWrData;
      if (a == `JRPSC_ADDR_LANE_PD) lanePd_r <= link.regWrData;    // see RULE_09
      if (a == `JRPSC_ADDR_REF_DIV) refDiv_r <= link.regWrData;    // see RULE_19
      if (a == `JRPSC_ADDR_CAL_CTRL_A) calCtrlA_r <= link.regWrData;
      if (a == `JRPSC_ADDR_CAL_CTRL_B) calCtrlB_r <= link.regWrData;
      if (a == `JRPSC_ADDR_OVR_A) ovrA_r <= link.regWrData;
      if (a == `JRPSC_ADDR_OVR_B) ovrB_r <= link.regWrData;
    end
  end

  // per-lane offset bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) ofs_r[i] <= 8'h00;
    end else if (we && isOfs) begin
      ofs_r[ofsIdx] <= link.regWrData;
    end
  end

  // read mux; unmapped offsets read zero
  wire logic [7:0] rdMux =
    (a == `JRPSC_ADDR_LINK_CFG)   ? linkCfg_r :
    (a == `JRPSC_ADDR_LINK_PWR)   ? linkPwr_r :
    (a == `JRPSC_ADDR_LANE_PD)    ? lanePd_r :
    (a == `JRPSC_ADDR_REF_DIV)    ? refDiv_r :
    (a == `JRPSC_ADDR_CAL_CTRL_A) ? calCtrlA_r :
    (a == `JRPSC_ADDR_CAL_CTRL_B) ? calCtrlB_r :
    (a == `JRPSC_ADDR_OVR_A)      ? ovrA_r :
    (a == `JRPSC_ADDR_OVR_B)      ? ovrB_r :
    (a == `JRPSC_ADDR_CODE_A)     ? {3'h0, calBusy, codeA_r} :  // see RULE_13
    (a == `JRPSC_ADDR_CODE_B)     ? {3'h0, calBusy, codeB_r} :
    isOfs                         ? ofs_r[ofsIdx] : 8'h00;

  // read answer one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r  <= link.regRdEn ? rdMux : rdData_r;
      rdValid_r <= link.regRdEn;
    end
  end

  // both start bits must be high; only a fresh rise starts a run
  wire logic bothGo = calCtrlA_r[`JRPSC_CAL_GO_BIT] & calCtrlB_r[`JRPSC_CAL_GO_BIT];
  wire logic calStart = bothGo & ~bothGo_r;  // see RULE_11 see RULE_20

  // shared calibration timer; each block latches its own trim result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bothGo_r <= 1'b0;
      calSt_r  <= CAL_IDLE;
      calCnt_r <= 6'h00;
      codeA_r  <= 4'h0;
      codeB_r  <= 4'h0;
    end else begin
      bothGo_r <= bothGo;
      case (calSt_r)
        CAL_IDLE: begin
          calCnt_r <= 6'h00;
          if (calStart) calSt_r <= CAL_RUN;
        end
        CAL_RUN: begin
          calCnt_r <= calCnt_r + 6'h01;
          if (calCnt_r == 6'(`JRPSC_CAL_CYCLES - 1)) begin
            codeA_r <= calMeasureA;  // see RULE_12
            codeB_r <= calMeasureB;
            calSt_r <= CAL_IDLE;
          end
        end
        default: calSt_r <= CAL_IDLE;
      endcase
    end
  end

  // eight identical lane trims; override skips the offset entirely
  localparam logic [7:0] BLK_A = `JRPSC_BLK_A_LANES;
  for (genvar i = 0; i < 8; i++) begin : g_lane
    wire logic [7:0]        ovr = BLK_A[i] ? ovrA_r : ovrB_r;   // see RULE_12
    wire logic [3:0]        cal = BLK_A[i] ? codeA_r : codeB_r;
    wire logic [2:0]        mag = ofs_r[i][2:0];
    wire logic signed [5:0] sum = ofs_r[i][`JRPSC_OFS_SIGN_BIT]
                                  ? $signed({2'h0, cal}) - $signed({3'h0, mag})
                                  : $signed({2'h0, cal}) + $signed({3'h0, mag});
    // saturate so a large trim cannot wrap to the far end of the range
    wire logic [3:0]        trim = sum[5] ? 4'h0 : (sum > 6'sh0F) ? 4'hF : sum[3:0];
    always_ff @(posedge clk or negedge resetn) begin  // see RULE_07
      if (!resetn) laneCode_r[i] <= 4'h0;
      else laneCode_r[i] <= ovr[`JRPSC_OVR_EN_BIT] ? {1'b0, ovr[3:1]}  // see RULE_14
                                                   : trim;            // see RULE_15
    end
    assign laneTermCode[4*i +: 4] = laneCode_r[i];
  end

  // link packing: F follows lane count, M is two with interpolation
  wire logic [3:0] lanes = linkCfg_r[3:0];
  wire logic [3:0] fNxt = (lanes == 4'h1) ? 4'h8 : (lanes == 4'h2) ? 4'h4 :
                          (lanes == 4'h4) ? 4'h2 : 4'h1;  // see RULE_02
  wire logic [1:0] mNxt = (linkCfg_r[7:4] != 4'h0) ? 2'h2 : 2'h1;  // see RULE_03

  // any powered lane losing sync, or link power off, requests resync
  wire logic resyncNxt = linkPwr_r[`JRPSC_PWR_DOWN_BIT] |
                         (|(laneSyncLost & ~lanePd_r));  // see RULE_05 see RULE_01

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      octetsPerFrame <= 4'h1;
      converterCount <= 2'h1;
      resync_r       <= 1'b1;
      linkPowerDown  <= 1'b1;
      lanePowerDown  <= `JRPSC_RST_LANE_PD;
    end else begin
      octetsPerFrame <= fNxt;
      converterCount <= mNxt;
      resync_r       <= resyncNxt;
      linkPowerDown  <= linkPwr_r[`JRPSC_PWR_DOWN_BIT];
      lanePowerDown  <= lanePd_r;  // see RULE_09
    end
  end

  // sysref: three stages, a rise counts when stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys1_r      <= 1'b0;
      sys2_r      <= 1'b0;
      sys3_r      <= 1'b0;
      sysStable_r <= 1'b0;
      sysrefPulse <= 1'b0;
    end else begin
      sys1_r      <= sysrefIn;
      sys2_r      <= sys1_r;
      sys3_r      <= sys2_r;
      sysStable_r <= (sys2_r == sys3_r) ? sys3_r : sysStable_r;
      sysrefPulse <= (sys2_r == sys3_r) & sys3_r & ~sysStable_r;  // see RULE_01
    end
  end

  // processing and frame enables from the byte tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byteCnt_r  <= 2'h0;
      frameCnt_r <= 3'h0;
      pclkEn     <= 1'b0;
      frameEn    <= 1'b0;
    end else begin
      byteCnt_r  <= byteTick ? byteCnt_r + 2'h1 : byteCnt_r;
      pclkEn     <= byteTick && (byteCnt_r == 2'(`JRPSC_BYTES_PER_PCLK - 1));  // see RULE_16
      frameCnt_r <= !byteTick ? frameCnt_r :
                    (frameCnt_r == 3'(fNxt - 4'h1)) ? 3'h0 : frameCnt_r + 3'h1;
      frameEn    <= byteTick && (frameCnt_r == 3'(fNxt - 4'h1));  // see RULE_17
    end
  end

  // lane PLL: oscillator halved, reference divided by the programmed factor
  wire logic [7:0] divLast = (refDiv_r == 8'h00) ? 8'h00 : refDiv_r - 8'h01;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quadPh_r  <= 1'b0;
      quadClkEn <= 1'b0;
      refCnt_r  <= 8'h00;
      pfdEn     <= 1'b0;
    end else begin
      quadPh_r  <= vcoTick ? ~quadPh_r : quadPh_r;
      quadClkEn <= vcoTick & quadPh_r;  // see RULE_18
      refCnt_r  <= !refTick ? refCnt_r : (refCnt_r >= divLast) ? 8'h00 : refCnt_r + 8'h01;
      pfdEn     <= refTick && (refCnt_r >= divLast);  // see RULE_19
    end
  end

  assign link.regRdData = rdData_r;
  assign link.regRdValid = rdValid_r;
  assign link.linkResyncRequestOut = resync_r;
endmodule
`default_nettype wire

// file: logic/jrpsc_host.sv
/*
  Transmitter-side controller: APB slave for software, single register
  accesses to the device, a bring-up sequence and lane rate checks.
  Assumes one clk shared with the device and a zero-wait APB master.
*/
`include "jrpsc_consts.svh"
`default_nettype none
module jrpsc_host
  import jrpsc_pkg::*;
(
  jrpsc_link_if.host      link,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic       pready,
  output var  logic       pslverr,
  output var  logic       txSendSync
);
  wire logic clk = link.clk;
  wire logic resetn = link.resetn;

  jrpsc_host_st_t st_r;
  logic [2:0]     step_r;
  logic [23:0]    linkCfg_r;
  logic [7:0]     lastRd_r;
  logic [11:0]    addr_r;
  logic [7:0]     wdata_r;
  logic           wrEn_r, rdEn_r;

  // APB decode; effects only at the completing edge
  wire logic apbDone = psel & penable & pready;
  wire logic apbWr = apbDone & pwrite;
  wire logic mapped = (paddr == `JRPSC_APB_CMD) || (paddr == `JRPSC_APB_STATUS) ||
                      (paddr == `JRPSC_APB_LINKCFG) || (paddr == `JRPSC_APB_CTRL);
  wire logic idle = (st_r == H_IDLE);
  wire logic cmdGo = apbWr && (paddr == `JRPSC_APB_CMD) && idle;
  wire logic seqGo = apbWr && (paddr == `JRPSC_APB_CTRL) && pwdata[0] && idle;

  // lane rate = 20 * data rate * M / L, M two when interpolating
  wire logic [15:0] dataRate = linkCfg_r[15:0];
  wire logic [3:0]  lanes = linkCfg_r[19:16];
  wire logic [23:0] rawRate = 24'(dataRate) * 24'(`JRPSC_BITS_FACTOR) *
                              ((linkCfg_r[23:20] != 4'h0) ? 24'h2 : 24'h1);
  wire logic [1:0]  lg = (lanes == 4'h8) ? 2'h3 : (lanes == 4'h4) ? 2'h2 :
                         (lanes == 4'h2) ? 2'h1 : 2'h0;
  wire logic        lanesOk = (lanes == 4'h1) | (lanes == 4'h2) | (lanes == 4'h4) |
                              (lanes == 4'h8);
  wire logic [23:0] laneRate = rawRate >> lg;
  wire logic        rateOk = lanesOk && (laneRate >= 24'(`JRPSC_LANE_MIN_MBPS)) &&
                             (laneRate <= 24'(`JRPSC_LANE_MAX_MBPS));  // see RULE_04
  // smallest power-of-two divider that brings the reference under the ceiling
  wire logic [23:0] refMhz = laneRate / 24'(`JRPSC_REF_RATIO);
  wire logic [1:0]  k = (refMhz <= 24'(`JRPSC_PFD_MAX_MHZ)) ? 2'h0 :
                        ((refMhz >> 1) <= 24'(`JRPSC_PFD_MAX_MHZ)) ? 2'h1 :
                        ((refMhz >> 2) <= 24'(`JRPSC_PFD_MAX_MHZ)) ? 2'h2 : 2'h3;
  wire logic [23:0] pfdMhz = refMhz >> k;
  wire logic        pfdOk = (pfdMhz >= 24'(`JRPSC_PFD_MIN_MHZ)) &&
                            (pfdMhz <= 24'(`JRPSC_PFD_MAX_MHZ));  // see RULE_19
  wire logic [7:0]  pdMask = ~((8'h01 << lanes) - 8'h01);  // unused lanes off

  // bring-up steps; start bits are cleared before being set
  logic [11:0] stepAddr;
  logic [7:0]  stepData;
  always_comb begin
    case (step_r)
      3'h0: begin stepAddr = `JRPSC_ADDR_LINK_PWR; stepData = 8'h00; end      // see RULE_08
      3'h1: begin stepAddr = `JRPSC_ADDR_LANE_PD; stepData = pdMask; end      // see RULE_09
      3'h2: begin stepAddr = `JRPSC_ADDR_LINK_CFG; stepData = {linkCfg_r[23:20], lanes}; end
      3'h3: begin stepAddr = `JRPSC_ADDR_REF_DIV; stepData = 8'h01 << k; end
      3'h4: begin stepAddr = `JRPSC_ADDR_CAL_CTRL_A; stepData = `JRPSC_TERM_SETUP_A & 8'hFE; end
      3'h5: begin stepAddr = `JRPSC_ADDR_CAL_CTRL_B; stepData = `JRPSC_TERM_SETUP_B & 8'hFE; end
      3'h6: begin stepAddr = `JRPSC_ADDR_CAL_CTRL_A; stepData = `JRPSC_TERM_SETUP_A | 8'h01; end
      default: begin stepAddr = `JRPSC_ADDR_CAL_CTRL_B; stepData = `JRPSC_TERM_SETUP_B | 8'h01; end
    endcase
  end

  // device access engine; commands while busy are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= H_IDLE; step_r <= 3'h0; addr_r <= 12'h000; wdata_r <= 8'h00;
      wrEn_r <= 1'b0; rdEn_r <= 1'b0; lastRd_r <= 8'h00;
    end else begin
      wrEn_r <= 1'b0;
      rdEn_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (cmdGo) begin
            addr_r <= pwdata[19:8]; wdata_r <= pwdata[7:0];
            wrEn_r <= ~pwdata[24]; rdEn_r <= pwdata[24];
            st_r   <= pwdata[24] ? H_RDWAIT : H_IDLE;
          end else if (seqGo) begin
            step_r <= 3'h0; st_r <= H_SEQ;
          end
        end
        H_SEQ: begin  // see RULE_10 see RULE_20
          addr_r <= stepAddr; wdata_r <= stepData; wrEn_r <= 1'b1;
          step_r <= step_r + 3'h1;
          if (step_r == 3'h7) st_r <= H_IDLE;
        end
        H_RDWAIT: begin
          if (link.regRdValid) begin
            lastRd_r <= link.regRdData; st_r <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // APB answer: ready in the access phase, data captured at setup
  wire logic [31:0] rdMux =
    (paddr == `JRPSC_APB_STATUS)  ? {20'h0, pfdOk, rateOk, link.linkResyncRequestOut,
                                     ~idle, lastRd_r} :
    (paddr == `JRPSC_APB_LINKCFG) ? {8'h00, linkCfg_r} : 32'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0; pslverr <= 1'b0; prdata <= 32'h0;
      linkCfg_r <= 24'h0; txSendSync <= 1'b1;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable) ? rdMux : prdata;
      if (apbWr && (paddr == `JRPSC_APB_LINKCFG)) linkCfg_r <= pwdata[23:0];
      txSendSync <= link.linkResyncRequestOut;  // see RULE_06
    end
  end

  assign link.regAddr = addr_r;
  assign link.regWrData = wdata_r;
  assign link.regWrEn = wrEn_r;
  assign link.regRdEn = rdEn_r;
endmodule
`default_nettype wire

// file: logic/jrpsc_link_if.sv
/*
  Carrier between the transmitter-side controller and the receiver device:
  a byte-wide register port plus the link-wide resync request.
  Assumes both ends share clk and resetn.
*/
`default_nettype none
interface jrpsc_link_if (
  input wire logic clk,
  input wire logic resetn
);
  logic [11:0] regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic        regRdValid;
  logic        linkResyncRequestOut;

  modport dev (input clk, resetn, regAddr, regWrData, regWrEn, regRdEn,
               output regRdData, regRdValid, linkResyncRequestOut);
  modport host (input clk, resetn, regRdData, regRdValid, linkResyncRequestOut,
                output regAddr, regWrData, regWrEn, regRdEn);
endinterface
`default_nettype wire

// file: logic/jrpsc_pkg.sv
/*
  Types shared by both ends of the link setup block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package jrpsc_pkg;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} jrpsc_cal_st_t;
  typedef enum logic [1:0] {H_IDLE, H_SEQ, H_RDWAIT} jrpsc_host_st_t;
endpackage
`default_nettype wire

// file: tb/jesd_rx_phy_setup_control_tb.sv
/*
  Testbench: APB master on the controller, device user side driven directly.
  Assumes the design files and the link interface are compiled first.
*/
`include "jrpsc_consts.svh"
`default_nettype none
module jesd_rx_phy_setup_control_tb import jrpsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, laneSyncLost = 8'hFF, lanePowerDown;
  logic [31:0] pwdata = 32'h0, prdata, rd, laneTermCode;
  logic byteTick = 1'b0, vcoTick = 1'b0, refTick = 1'b0, sysrefIn = 1'b0, sysrefPulse;
  logic [3:0] calMeasureA = 4'h9, calMeasureB = 4'h4, octetsPerFrame;
  logic pready, pslverr, txSendSync, err, linkPowerDown, pclkEn, frameEn, quadClkEn, pfdEn;
  logic [1:0] converterCount;
  int errors = 0, compares = 0, nPclk = 0, nFrame = 0, nQuad = 0, nPfd = 0, nSys = 0;
  logic [31:0] cfgTab [3] = '{32'h00180095, 32'h00180096, 32'h001403E8};
  always #10 clk = ~clk;
  jrpsc_link_if lnk (.clk(clk), .resetn(resetn));
  jrpsc_dev u_jrpsc_dev (.link(lnk), .byteTick(byteTick), .laneSyncLost(laneSyncLost),
    .sysrefIn(sysrefIn), .calMeasureA(calMeasureA), .calMeasureB(calMeasureB),
    .vcoTick(vcoTick), .refTick(refTick), .linkPowerDown(linkPowerDown),
    .lanePowerDown(lanePowerDown), .laneTermCode(laneTermCode), .converterCount(converterCount),
    .octetsPerFrame(octetsPerFrame), .pclkEn(pclkEn), .frameEn(frameEn), .sysrefPulse(sysrefPulse),
    .quadClkEn(quadClkEn), .pfdEn(pfdEn));
  jrpsc_host u_jrpsc_host (.link(lnk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txSendSync(txSendSync));
  jrpsc_link_props u_jrpsc_link_props (.clk(clk), .resetn(resetn), .regAddr(lnk.regAddr),
    .regWrData(lnk.regWrData), .regWrEn(lnk.regWrEn), .regRdEn(lnk.regRdEn),
    .regRdData(lnk.regRdData), .regRdValid(lnk.regRdValid),
    .linkResyncRequestOut(lnk.linkResyncRequestOut));
  // pulse counters for the rate enables and the sysref pulse
  always @(posedge clk) begin
    if (pclkEn === 1'b1) nPclk++;
    if (frameEn === 1'b1) nFrame++;
    if (quadClkEn === 1'b1) nQuad++;
    if (pfdEn === 1'b1) nPfd++;
    if (sysrefPulse === 1'b1) nSys++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) errors++;
  endtask
  // device accesses go through the command word; gap keeps clear of the busy drop
  task automatic devWr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, `JRPSC_APB_CMD, {12'h000, a, d});
    repeat (4) @(posedge clk);
  endtask
  task automatic devChk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b1, `JRPSC_APB_CMD, {7'h00, 1'b1, 4'h0, a, 8'h00});
    repeat (4) @(posedge clk);
    apb(1'b0, `JRPSC_APB_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, exp});
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    waitc(1);
    chk(32'(lanePowerDown), 32'h000000FF);
    chk(32'(txSendSync), 32'h1);
    devChk(`JRPSC_ADDR_LINK_PWR, 8'h01);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1); // unmapped controller word is refused
    devChk(12'hFFF, 8'h00);
    // lane rate window, both edges of the lower bound
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `JRPSC_APB_LINKCFG, cfgTab[i]);
      apb(1'b0, `JRPSC_APB_STATUS, 32'h0);
      chk(32'(rd[10]), 32'(i != 0));
      chk(32'(rd[11]), 32'(i == 2));
    end
    apb(1'b1, `JRPSC_APB_CTRL, 32'h1);
    waitc(80);
    chk(32'(lanePowerDown), 32'h000000F0);
    chk(32'(linkPowerDown), 32'h0);
    chk(32'(converterCount), 32'h2);
    chk(32'(octetsPerFrame), 32'h2);
    devChk(`JRPSC_ADDR_LANE_PD, 8'hF0);
    devChk(`JRPSC_ADDR_CODE_A, 8'h09);
    devChk(`JRPSC_ADDR_CODE_B, 8'h04);
    devChk(`JRPSC_ADDR_REF_DIV, 8'h04);
    // trims: plus two, minus one, and one that saturates
    devWr(12'h2BB, 8'h02);
    devWr(12'h2BD, 8'h09);
    devWr(`JRPSC_ADDR_OFS_LAST, 8'h07);
    waitc(2);
    chk(laneTermCode, 32'hF944439B);
    devWr(`JRPSC_ADDR_OVR_A, 8'h1A);
    waitc(2);
    chk(laneTermCode, 32'h55444355);
    devWr(`JRPSC_ADDR_OVR_A, 8'h00);
    calMeasureA <= 4'h3;
    devWr(`JRPSC_ADDR_CAL_CTRL_A, 8'h03);
    waitc(60);
    devChk(`JRPSC_ADDR_CODE_A, 8'h09);
    for (int i = 0; i < 4; i++)
      devWr(i[0] ? `JRPSC_ADDR_CAL_CTRL_B : `JRPSC_ADDR_CAL_CTRL_A, {6'h00, 1'b1, i[1]});
    waitc(60);
    devChk(`JRPSC_ADDR_CODE_A, 8'h03);
    laneSyncLost <= 8'h00;
    waitc(3);
    chk(32'(txSendSync), 32'h0);
    laneSyncLost <= 8'h10;
    waitc(3);
    chk(32'(txSendSync), 32'h0);
    laneSyncLost <= 8'h04;
    waitc(3);
    chk(32'(txSendSync), 32'h1);
    devWr(`JRPSC_ADDR_LANE_PD, 8'hFF);
    laneSyncLost <= 8'hFF;
    waitc(3);
    chk(32'(txSendSync), 32'h0);
    for (int i = 0; i < 4; i++) begin
      devWr(`JRPSC_ADDR_LINK_CFG, 8'(1 << i));
      waitc(1);
      chk(32'(octetsPerFrame), 32'(8 >> i));
      chk(32'(converterCount), 32'h1);
    end
    devWr(`JRPSC_ADDR_LINK_CFG, 8'h12);
    devWr(`JRPSC_ADDR_REF_DIV, 8'h03);
    sysrefIn <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      {byteTick, vcoTick, refTick} <= 3'h7;
      @(posedge clk);
      {byteTick, vcoTick, refTick} <= 3'h0;
    end
    waitc(4);
    chk(32'(nPclk), 32'h3);
    chk(32'(nFrame), 32'h3);
    chk(32'(nQuad), 32'h6);
    chk(32'(nPfd), 32'h4);
    chk(32'(nSys), 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: tb/jrpsc_link_props.sv
/*
  Checker for the register port and resync line between controller and device.
  Assumes it is instantiated beside the link interface and sees its signals.
*/
`include "jrpsc_consts.svh"
`default_nettype none
module jrpsc_link_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic        regRdValid,
  input wire logic        linkResyncRequestOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pwrDown_r;
  logic [7:0] lanePd_r;
  wire        wrPwr  = regWrEn && (regAddr == `JRPSC_ADDR_LINK_PWR);
  wire        wrLane = regWrEn && (regAddr == `JRPSC_ADDR_LANE_PD);
  // shadow of the power registers, so resync can be judged without peeking inside
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwrDown_r <= 1'b1;
      lanePd_r  <= 8'hFF;
    end else begin
      if (wrPwr) pwrDown_r <= regWrData[0];
      if (wrLane) lanePd_r <= regWrData;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // calibration start bits: both cleared, then both raised
  sequence s_cal(logic [11:0] a, logic b);
    regWrEn && regAddr == a && regWrData[0] == b;
  endsequence
  sequence s_clr;
    s_cal(`JRPSC_ADDR_CAL_CTRL_A, 1'b0) ##1 s_cal(`JRPSC_ADDR_CAL_CTRL_B, 1'b0);
  endsequence
  sequence s_set;
    s_cal(`JRPSC_ADDR_CAL_CTRL_A, 1'b1) ##1 s_cal(`JRPSC_ADDR_CAL_CTRL_B, 1'b1);
  endsequence
  a_rd_valid_next: assert property (regRdEn |=> regRdValid)
    else $error("read strobe got no valid");
  a_rd_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("valid without a read");
  a_rd_data_hold: assert property (!regRdValid |-> $stable(regRdData))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (regRdEn && regAddr == 12'hFFF |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_lane_pd_read: assert property (regRdEn && wrLane == 1'b0 && regAddr == `JRPSC_ADDR_LANE_PD
    |=> regRdData == lanePd_r)
    else $error("lane power readback wrong");
  a_pwr_resync: assert property (pwrDown_r ##1 pwrDown_r |=> linkResyncRequestOut)
    else $error("resync low while link powered down");
  a_masked_quiet: assert property ((!pwrDown_r && lanePd_r == 8'hFF) [*2] |=> !linkResyncRequestOut)
    else $error("resync from powered-down lanes");
  a_cal_order: assert property (s_clr |=> s_set)
    else $error("calibration start bits not raised after clearing");
  a_cal_setup: assert property (regWrEn && regAddr == `JRPSC_ADDR_CAL_CTRL_A
    |-> (regWrData & 8'hFE) == (`JRPSC_TERM_SETUP_A & 8'hFE))
    else $error("calibration control written without setup value");
endmodule
`default_nettype wire
